/* File: hdl/cies_pkg.sv */
// Purpose: Constants for the instruction execution subset block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Flag bit positions match the FLAGS register layout
// Contract
// - Subtract sets carry when difference is zero or positive, clears when negative
// - minus_into_memory writes work minus memory back to memory, work unchanged
// - Immediate subtract stores work minus constant into working_register
// - All subtract forms update overflow, zero, half carry and carry flags
// - nibble_exchange swaps memory nibbles in place, flags unchanged
// - skip_if_memory_null skips next instruction when memory byte is zero
// - Every skip-type operation takes two machine cycles
// - copy_then_skip_if_null copies byte to work, skips if zero, flags unchanged
// - Bit-test skip skips when selected memory bit is zero, flags unchanged
// - table_fetch_current_page reads current-page word: low byte to memory, high to latch
// - table_fetch_last_page does the same from the last program page
// - exclusive_or_into_work stores work xor memory in work, updates zero only
// - exclusive_or_into_memory stores work xor memory in memory, updates zero only
// - Immediate exclusive-or stores work xor constant in work, updates zero only
package cies_pkg;

    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PROG_W      = 15;
    localparam int unsigned PROG_AW     = 12;
    localparam int unsigned DMEM_DEPTH  = 192;
    localparam logic [3:0]  LAST_PAGE   = 4'hf;

    // Register byte offsets
    localparam logic [7:0]  OFS_CMD     = 8'h00;
    localparam logic [7:0]  OFS_OPND    = 8'h04;
    localparam logic [7:0]  OFS_WORK    = 8'h08;
    localparam logic [7:0]  OFS_FLAGS   = 8'h0c;
    localparam logic [7:0]  OFS_TPTR    = 8'h10;
    localparam logic [7:0]  OFS_THIGH   = 8'h14;
    localparam logic [7:0]  OFS_STATUS  = 8'h18;
    localparam logic [7:0]  OFS_DMEM    = 8'h1c;

    // Field positions
    localparam int unsigned CMD_OP_LSB  = 0;
    localparam int unsigned CMD_BIT_LSB = 4;
    localparam int unsigned OPND_IMM_LSB = 8;
    localparam int unsigned TPTR_PAGE_LSB = 8;
    localparam int unsigned FLG_C       = 0;
    localparam int unsigned FLG_HC      = 1;
    localparam int unsigned FLG_Z       = 2;
    localparam int unsigned FLG_SR      = 3;
    localparam int unsigned STS_BUSY    = 0;
    localparam int unsigned STS_SKIP    = 1;

    // Reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [3:0]  RST_FLAGS   = 4'h0;
    localparam logic [3:0]  RST_PAGE    = 4'h0;

    typedef enum logic [3:0] {
        CIES_OP_SUB_MEM  = 4'h0,
        CIES_OP_SUB_TOM  = 4'h1,
        CIES_OP_SUB_IMM  = 4'h2,
        CIES_OP_SWAP     = 4'h3,
        CIES_OP_SWAP_TOW = 4'h4,
        CIES_OP_SKZ      = 4'h5,
        CIES_OP_SKZ_CPY  = 4'h6,
        CIES_OP_SKZ_BIT  = 4'h7,
        CIES_OP_TAB_CUR  = 4'h8,
        CIES_OP_TAB_LAST = 4'h9,
        CIES_OP_XOR_MEM  = 4'ha,
        CIES_OP_XOR_TOM  = 4'hb,
        CIES_OP_XOR_IMM  = 4'hc
    } cies_op_e;

    typedef enum logic [1:0] {
        CIES_ST_IDLE  = 2'b00,
        CIES_ST_EXEC  = 2'b01,
        CIES_ST_SKIP  = 2'b10,
        CIES_ST_TABLE = 2'b11
    } cies_state_e;

endpackage : cies_pkg

/* File: hdl/cies_core.sv */
// Purpose: Executes subtract, nibble swap, skip, table read and xor operations
// Assumes: Program memory answers in the same cycle that prog_rd is high, on the same clock
// Notes:   Data memory lives here as flip-flops; addresses past its end read zero
module cies_core
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             prog_rd,
    output logic      [11:0] prog_addr,
    input  wire logic [14:0] prog_data,
    output logic             skip_next,
    output logic             busy
);

    cies_pkg::cies_state_e state;
    cies_pkg::cies_state_e next_state;
    cies_pkg::cies_op_e    op;
    logic [2:0]            bit_sel;
    logic [7:0]            opnd_addr;
    logic [7:0]            opnd_imm;
    logic [7:0]            working_register;
    logic [3:0]            flags;
    logic [7:0]            table_pointer;
    logic [3:0]            cur_page;
    logic [7:0]            table_high_latch;
    logic                  last_skip;
    logic [7:0]            dmem [cies_pkg::DMEM_DEPTH];

    logic       setup;
    logic       wr_acc;
    logic       mapped;
    logic       start;
    logic [7:0] mem_byte;
    logic [7:0] sub_b;
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic [7:0] xor_b;
    logic [7:0] xor_res;
    logic       skip_take;
    logic       is_skip_op;

    function automatic logic [7:0] nib_swap(input logic [7:0] v);
        nib_swap = {v[3:0], v[7:4]};
    endfunction : nib_swap

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (32'(a) < cies_pkg::DMEM_DEPTH);
    endfunction : addr_ok

    function automatic logic [7:0] mem_rd(input logic [7:0] a, input logic [7:0] v);
        mem_rd = addr_ok(a) ? v : cies_pkg::RST_BYTE;
    endfunction : mem_rd

    // Register writes land only while idle, so an operand never changes mid-operation
    function automatic logic reg_wr(input logic [7:0] ofs);
        reg_wr = wr_acc && (paddr == ofs) && !busy;
    endfunction : reg_wr

    // APB decode
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    always_comb
    begin
        case (paddr)
            cies_pkg::OFS_CMD, cies_pkg::OFS_OPND, cies_pkg::OFS_WORK, cies_pkg::OFS_FLAGS,
            cies_pkg::OFS_TPTR, cies_pkg::OFS_THIGH, cies_pkg::OFS_STATUS, cies_pkg::OFS_DMEM:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    // A command written while busy is dropped so an operation never changes mid-flight
    assign start = wr_acc && (paddr == cies_pkg::OFS_CMD) && (state == cies_pkg::CIES_ST_IDLE);
    assign busy  = (state != cies_pkg::CIES_ST_IDLE);

    // Operand and arithmetic paths
    assign mem_byte = mem_rd(opnd_addr, dmem[opnd_addr % 8'(cies_pkg::DMEM_DEPTH)]);
    assign sub_b   = (op == cies_pkg::CIES_OP_SUB_IMM) ? opnd_imm : mem_byte;
    assign diff    = {1'b0, working_register} - {1'b0, sub_b};
    assign diff_lo = {1'b0, working_register[3:0]} - {1'b0, sub_b[3:0]};
    assign xor_b   = (op == cies_pkg::CIES_OP_XOR_IMM) ? opnd_imm : mem_byte;
    assign xor_res = working_register ^ xor_b;

    always_comb
    begin
        is_skip_op = 1'b0;
        skip_take  = 1'b0;
        case (op)
            cies_pkg::CIES_OP_SKZ,
            cies_pkg::CIES_OP_SKZ_CPY:
            begin
                is_skip_op = 1'b1;
                skip_take  = (mem_byte == cies_pkg::RST_BYTE);
            end
            cies_pkg::CIES_OP_SKZ_BIT:
            begin
                is_skip_op = 1'b1;
                skip_take  = !mem_byte[bit_sel];
            end
            default:
            begin
                is_skip_op = 1'b0;
                skip_take  = 1'b0;
            end
        endcase
    end

    // Sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            cies_pkg::CIES_ST_IDLE:
                if (start)
                    next_state = cies_pkg::CIES_ST_EXEC;
            cies_pkg::CIES_ST_EXEC:
                if (is_skip_op)
                    next_state = cies_pkg::CIES_ST_SKIP;
                else if (op == cies_pkg::CIES_OP_TAB_CUR || op == cies_pkg::CIES_OP_TAB_LAST)
                    next_state = cies_pkg::CIES_ST_TABLE;
                else
                    next_state = cies_pkg::CIES_ST_IDLE;
            cies_pkg::CIES_ST_SKIP:
                next_state = cies_pkg::CIES_ST_IDLE;
            cies_pkg::CIES_ST_TABLE:
                next_state = cies_pkg::CIES_ST_IDLE;
            default:
                next_state = cies_pkg::CIES_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state <= cies_pkg::CIES_ST_IDLE;
        else
            state <= next_state;
    end

    // Command and operand registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            op      <= cies_pkg::CIES_OP_SUB_MEM;
            bit_sel <= 3'h0;
        end
        else if (start)
        begin
            op      <= cies_pkg::cies_op_e'(pwdata[cies_pkg::CMD_OP_LSB +: 4]);
            bit_sel <= pwdata[cies_pkg::CMD_BIT_LSB +: 3];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            opnd_addr <= cies_pkg::RST_BYTE;
            opnd_imm  <= cies_pkg::RST_BYTE;
        end
        else if (reg_wr(cies_pkg::OFS_OPND))
        begin
            opnd_addr <= pwdata[7:0];
            opnd_imm  <= pwdata[cies_pkg::OPND_IMM_LSB +: 8];
        end
    end

    // Working register
    always_ff @(posedge clock)
    begin
        if (rst)
            working_register <= cies_pkg::RST_BYTE;
        else if (state == cies_pkg::CIES_ST_EXEC)
        begin
            case (op)
                cies_pkg::CIES_OP_SUB_MEM,
                cies_pkg::CIES_OP_SUB_IMM:
                    working_register <= diff[7:0];
                cies_pkg::CIES_OP_SWAP_TOW:
                    working_register <= nib_swap(mem_byte);
                cies_pkg::CIES_OP_SKZ_CPY:
                    working_register <= mem_byte;
                cies_pkg::CIES_OP_XOR_MEM,
                cies_pkg::CIES_OP_XOR_IMM:
                    working_register <= xor_res;
                default:
                    working_register <= working_register;
            endcase
        end
        else if (reg_wr(cies_pkg::OFS_WORK))
            working_register <= pwdata[7:0];
    end

    // Status flags; carry is an inverted borrow
    always_ff @(posedge clock)
    begin
        if (rst)
            flags <= cies_pkg::RST_FLAGS;
        else if (state == cies_pkg::CIES_ST_EXEC)
        begin
            case (op)
                cies_pkg::CIES_OP_SUB_MEM,
                cies_pkg::CIES_OP_SUB_TOM,
                cies_pkg::CIES_OP_SUB_IMM:
                begin
                    flags[cies_pkg::FLG_C]  <= !diff[8];
                    flags[cies_pkg::FLG_HC] <= !diff_lo[4];
                    flags[cies_pkg::FLG_Z]  <= (diff[7:0] == cies_pkg::RST_BYTE);
                    flags[cies_pkg::FLG_SR] <= (working_register[7] != sub_b[7])
                                               && (diff[7] != working_register[7]);
                end
                cies_pkg::CIES_OP_XOR_MEM,
                cies_pkg::CIES_OP_XOR_TOM,
                cies_pkg::CIES_OP_XOR_IMM:
                    flags[cies_pkg::FLG_Z] <= (xor_res == cies_pkg::RST_BYTE);
                default:
                    flags <= flags;
            endcase
        end
        else if (reg_wr(cies_pkg::OFS_FLAGS))
            flags <= pwdata[3:0];
    end

    // Data memory; one write port shared by execution and the bus window
    always_ff @(posedge clock)
    begin
        if (state == cies_pkg::CIES_ST_EXEC && addr_ok(opnd_addr))
        begin
            case (op)
                cies_pkg::CIES_OP_SUB_TOM:
                    dmem[opnd_addr] <= diff[7:0];
                cies_pkg::CIES_OP_SWAP:
                    dmem[opnd_addr] <= nib_swap(mem_byte);
                cies_pkg::CIES_OP_XOR_TOM:
                    dmem[opnd_addr] <= xor_res;
                default:
                    dmem[opnd_addr] <= dmem[opnd_addr];
            endcase
        end
        else if (state == cies_pkg::CIES_ST_TABLE && addr_ok(opnd_addr))
            dmem[opnd_addr] <= prog_data[7:0];
        else if (reg_wr(cies_pkg::OFS_DMEM) && addr_ok(opnd_addr))
            dmem[opnd_addr] <= pwdata[7:0];
    end

    // Table pointer and page select
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            table_pointer <= cies_pkg::RST_BYTE;
            cur_page      <= cies_pkg::RST_PAGE;
        end
        else if (reg_wr(cies_pkg::OFS_TPTR))
        begin
            table_pointer <= pwdata[7:0];
            cur_page      <= pwdata[cies_pkg::TPTR_PAGE_LSB +: 4];
        end
    end

    // Program memory request, issued from the execute cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            prog_rd   <= 1'b0;
            prog_addr <= 12'h000;
        end
        else if (state == cies_pkg::CIES_ST_EXEC && op == cies_pkg::CIES_OP_TAB_CUR)
        begin
            prog_rd   <= 1'b1;
            prog_addr <= {cur_page, table_pointer};
        end
        else if (state == cies_pkg::CIES_ST_EXEC && op == cies_pkg::CIES_OP_TAB_LAST)
        begin
            prog_rd   <= 1'b1;
            prog_addr <= {cies_pkg::LAST_PAGE, table_pointer};
        end
        else
            prog_rd <= 1'b0;
    end

    // High part of a program word is only seven bits wide
    always_ff @(posedge clock)
    begin
        if (rst)
            table_high_latch <= cies_pkg::RST_BYTE;
        else if (state == cies_pkg::CIES_ST_TABLE)
            table_high_latch <= {1'b0, prog_data[14:8]};
    end

    // Skip outcome, reported as a pulse and held for software
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            skip_next <= 1'b0;
            last_skip <= 1'b0;
        end
        else if (state == cies_pkg::CIES_ST_EXEC)
        begin
            skip_next <= skip_take;
            last_skip <= skip_take;
        end
        else
            skip_next <= 1'b0;
    end

    // Read data is captured in the setup phase so the access phase needs no wait
    always_ff @(posedge clock)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            case (paddr)
                cies_pkg::OFS_CMD:    prdata <= {25'h0, bit_sel, op};
                cies_pkg::OFS_OPND:   prdata <= {16'h0, opnd_imm, opnd_addr};
                cies_pkg::OFS_WORK:   prdata <= {24'h0, working_register};
                cies_pkg::OFS_FLAGS:  prdata <= {28'h0, flags};
                cies_pkg::OFS_TPTR:   prdata <= {20'h0, cur_page, table_pointer};
                cies_pkg::OFS_THIGH:  prdata <= {24'h0, table_high_latch};
                cies_pkg::OFS_STATUS: prdata <= {30'h0, last_skip, busy};
                cies_pkg::OFS_DMEM:   prdata <= {24'h0, mem_byte};
                default:              prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : cies_core

/* File: verif/cies_core_asserts.sv */
// Purpose: Port-level checks for cies_core
// Assumes: One clock, synchronous reset
// Notes:   Commands only count when busy is low
module cies_core_asserts
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        prog_rd,
    input wire logic [11:0] prog_addr,
    input wire logic        skip_next,
    input wire logic        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [3:0] op;
    logic       go;
    // Busy gating mirrors the bus rule that commands are dropped mid-run
    assign op = pwdata[3:0];
    assign go = psel && penable && pwrite && paddr == 8'h00 && !busy;
    sequence s_one;
        busy ##1 !busy;
    endsequence
    sequence s_two;
        busy [*2] ##1 !busy;
    endsequence
    sequence s_fetch;
        !prog_rd ##1 prog_rd ##1 (!prog_rd && !busy);
    endsequence
    property p_simple_len;
        go && (op < 4'h5 || op inside {[4'ha:4'hc]}) |=> s_one;
    endproperty
    a_simple_len: assert property (p_simple_len) else $error("simple op length wrong");
    property p_skip_len;
        go && op inside {[4'h5:4'h7]} |=> s_two;
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip op length wrong");
    property p_skip_late;
        go && op inside {[4'h5:4'h7]} |=> !skip_next;
    endproperty
    a_skip_late: assert property (p_skip_late) else $error("skip pulse too early");
    property p_tab_fetch;
        go && op inside {4'h8, 4'h9} |=> s_fetch;
    endproperty
    a_tab_fetch: assert property (p_tab_fetch) else $error("table fetch timing wrong");
    property p_last_page;
        go && op == 4'h9 |-> ##2 prog_addr[11:8] == 4'hf;
    endproperty
    a_last_page: assert property (p_last_page) else $error("last page not used");
    property p_rd_pulse;
        prog_rd |-> busy ##1 !prog_rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("program read not a pulse");
    property p_no_rd;
        go && !(op inside {4'h8, 4'h9}) |=> !prog_rd [*3];
    endproperty
    a_no_rd: assert property (p_no_rd) else $error("stray program read");
    property p_skip_pulse;
        skip_next |-> busy ##1 !skip_next;
    endproperty
    a_skip_pulse: assert property (p_skip_pulse) else $error("skip pulse wrong");
    property p_no_skip;
        go && !(op inside {[4'h5:4'h7]}) |=> !skip_next [*3];
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("skip from non-skip op");
endmodule : cies_core_asserts

bind cies_core cies_core_asserts i_asserts (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .skip_next(skip_next), .busy(busy));

/* File: verif/cies_prog_model.sv */
// Purpose: Program memory behind the table fetch port
// Assumes: Word valid in the request cycle and the one after
// Notes:   Outside that window the bus shows the inverse of the last word
module cies_prog_model
(
    input  wire logic        clock,
    input  wire logic        prog_rd,
    input  wire logic [11:0] prog_addr,
    output logic      [14:0] prog_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        rd_q = 1'b0;
    logic [14:0] last = 15'h0000;
    function automatic logic [14:0] word(input logic [11:0] a);
        return {{a[11:8], a[2:0]} ^ 7'h2a, a[7:0] ^ 8'hc3};
    endfunction : word
    // Stale data is never repeated, so a late sample cannot pass by luck
    assign prog_data = (prog_rd || rd_q) ? word(prog_addr) : ~last;
    always @(posedge clock)
    begin
        rd_q <= prog_rd;
        if (prog_rd || rd_q)
            last <= word(prog_addr);
    end
endmodule : cies_prog_model

/* File: verif/cies_core_bench.sv */
// Purpose: Self-checking bench for cies_core
// Assumes: Zero-wait APB, busy polled after each command
// Notes:   Operand byte always at data address 0x23
module cies_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, prog_rd, skip_next, busy, e;
    logic [11:0] prog_addr;
    logic [14:0] prog_data;
    int          fail_count = 0, check_count = 0, cycles = 0, skips = 0;
    always #2.5 clock = ~clock;
    cies_core i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data), .skip_next(skip_next),
        .busy(busy));
    cies_prog_model i_prog (.clock(clock), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .prog_data(prog_data));
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (skip_next === 1'b1)
            skips <= skips + 1;
        // Whole run needs about 1200 cycles
        if (cycles == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    task check(input string n, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask : check
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(n, q, x);
        check("slverr", {31'h0, e}, 32'h0);
    endtask : rd_chk
    task run(input logic [3:0] c, input logic [2:0] b);
        apb(1'b1, 8'h00, {25'h0, b, c});
        @(posedge clock);
        while (busy !== 1'b0)
            @(posedge clock);
    endtask : run
    task prep(input logic [7:0] w, input logic [7:0] m, input logic [7:0] imm, input logic [3:0] f);
        apb(1'b1, 8'h04, {16'h0, imm, 8'h23});
        apb(1'b1, 8'h1c, {24'h0, m});
        apb(1'b1, 8'h08, {24'h0, w});
        apb(1'b1, 8'h0c, {28'h0, f});
    endtask : prep
    task exp3(input logic [7:0] w, input logic [7:0] m, input logic [3:0] f);
        rd_chk("work", 8'h08, {24'h0, w});
        rd_chk("mem", 8'h1c, {24'h0, m});
        rd_chk("flags", 8'h0c, {28'h0, f});
    endtask : exp3
    task t_reset;
        rd_chk("status", 8'h18, 32'h0);
        check("pready", {31'h0, pready}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        check("slverr", {31'h0, e}, 32'h1);
        apb(1'b1, 8'h14, 32'hff);
        rd_chk("thigh", 8'h14, 32'h0);
    endtask : t_reset
    task t_sub;
        logic [7:0] a [5] = '{8'h50, 8'h30, 8'h42, 8'h80, 8'h7f};
        logic [7:0] b [5] = '{8'h30, 8'h50, 8'h42, 8'h01, 8'hff};
        logic [7:0] r [5] = '{8'h20, 8'he0, 8'h00, 8'h7f, 8'h80};
        // Flags {signed range, zero, half carry, carry}, worked out by hand
        logic [3:0] f [5] = '{4'h3, 4'h2, 4'h7, 4'h9, 4'ha};
        for (int i = 0; i < 5; i++)
        begin
            prep(a[i], b[i], 8'h00, ~f[i]);
            run(4'h0, 3'h0);
            exp3(r[i], b[i], f[i]);
            prep(a[i], b[i], 8'h00, ~f[i]);
            run(4'h1, 3'h0);
            exp3(a[i], r[i], f[i]);
            prep(a[i], 8'h00, b[i], ~f[i]);
            run(4'h2, 3'h0);
            exp3(r[i], 8'h00, f[i]);
        end
    endtask : t_sub
    task t_swap;
        prep(8'h11, 8'h3c, 8'h00, 4'ha);
        run(4'h3, 3'h0);
        exp3(8'h11, 8'hc3, 4'ha);
        prep(8'h11, 8'h3c, 8'h00, 4'h5);
        run(4'h4, 3'h0);
        exp3(8'hc3, 8'h3c, 4'h5);
    endtask : t_swap
    task sk(input logic [3:0] c, input logic [2:0] b, input logic [7:0] m, input logic x);
        int s0;
        prep(8'h99, m, 8'h00, 4'h6);
        s0 = skips;
        run(c, b);
        check("skips", 32'(skips - s0), {31'h0, x});
        rd_chk("status", 8'h18, {30'h0, x, 1'b0});
        exp3((c == 4'h6) ? m : 8'h99, m, 4'h6);
    endtask : sk
    task t_skip;
        sk(4'h5, 3'h0, 8'h00, 1'b1);
        sk(4'h5, 3'h0, 8'h40, 1'b0);
        sk(4'h6, 3'h0, 8'h00, 1'b1);
        sk(4'h6, 3'h0, 8'h81, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            sk(4'h7, 3'(i), ~(8'h01 << i), 1'b1);
            sk(4'h7, 3'(i), 8'h01 << i, 1'b0);
        end
    endtask : t_skip
    task t_table;
        logic [11:0] a;
        logic [14:0] w;
        apb(1'b1, 8'h10, {20'h0, 4'h3, 8'h5a});
        for (int i = 0; i < 2; i++)
        begin
            a = {(i == 1) ? 4'hf : 4'h3, 8'h5a};
            w = {{a[11:8], a[2:0]} ^ 7'h2a, a[7:0] ^ 8'hc3};
            prep(8'h77, 8'h00, 8'h00, 4'h9);
            run(4'h8 + 4'(i), 3'h0);
            exp3(8'h77, w[7:0], 4'h9);
            rd_chk("thigh", 8'h14, {25'h0, w[14:8]});
        end
    endtask : t_table
    task t_xor;
        prep(8'h5a, 8'h5a, 8'h00, 4'hb);
        run(4'ha, 3'h0);
        exp3(8'h00, 8'h5a, 4'hf);
        prep(8'h5a, 8'h0f, 8'h00, 4'hf);
        run(4'hb, 3'h0);
        exp3(8'h5a, 8'h55, 4'hb);
        prep(8'h5a, 8'h00, 8'h5a, 4'h0);
        run(4'hc, 3'h0);
        exp3(8'h00, 8'h00, 4'h4);
    endtask : t_xor
    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_sub();
        t_swap();
        t_skip();
        t_table();
        t_xor();
        end_of_test();
    end
endmodule : cies_core_bench
